// [inc/tkc2_pkg.sv]
// Constants, state codes and carrier types of the second touch-key sequencer.
// Assumes one system clock that also stands for the internal oscillator.
package tkc2_pkg;

  // Register port widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // Register byte addresses
  localparam logic [15:0] A_CFG  = 16'ha150;
  localparam logic [15:0] A_AFG  = 16'ha151;
  localparam logic [15:0] A_CMD  = 16'ha152;
  localparam logic [15:0] A_CNTL = 16'ha153;
  localparam logic [15:0] A_CNTH = 16'ha154;
  localparam logic [15:0] A_STAT = 16'ha155;
  localparam logic [15:0] A_MASK = 16'ha156;

  // Reset values
  localparam logic [7:0] CFG_RST  = 8'h00;
  localparam logic [7:0] AFG_RST  = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h03;

  // Field positions of touch2_config
  localparam int CFG_EN   = 7;
  localparam int CFG_PSR  = 6;
  localparam int CFG_VREF = 5;
  localparam int CFG_VTH  = 4;
  localparam int CFG_CD   = 0;
  // Field positions of touch2_analog_config
  localparam int AFG_PAD  = 7;
  localparam int AFG_ZERO = 4;
  localparam int AFG_FIL  = 0;
  // Field positions of touch2_command_interrupt
  localparam int CMD_INTEN = 7;
  localparam int CMD_CNTHI = 5;
  localparam int CMD_SHIFT = 4;
  localparam int CMD_RPT   = 2;
  localparam int CMD_FLAG  = 1;
  localparam int CMD_START = 0;
  // Status and mask bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_OVF  = 1;

  // Widths of counts
  localparam int CNT_W = 18;
  localparam int TMR_W = 11;

  // Discharge timing, in system clock periods
  localparam logic [10:0] ZERO_PRE  = 11'h004;
  localparam logic [10:0] ZERO_UNIT = 11'h080;
  localparam logic [10:0] ZERO_POST = 11'h001;
  localparam logic [10:0] LEN_ADD   = 11'h001;

  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_ZERO   = 5'h02,
    ST_CHARGE = 5'h04,
    ST_DUMP   = 5'h08,
    ST_FINISH = 5'h10
  } tkc2_state_t;

  // Register port request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } tkc2_bus_t;

  // Drives toward the analog front end
  typedef struct packed {
    logic ref_zero;
    logic pad_nmos;
    logic charge;
    logic dump;
    logic pseudo_random_enable;
    logic reference_select;
    logic comparator_threshold_select;
  } tkc2_front_t;

endpackage

// [src/tkc2_interval.sv]
// Loadable down-counter timing one sequencer phase.
// Assumes the loader never loads zero.
`timescale 1ns/10ps
module tkc2_interval #(
  parameter int W = 11
) (
  // Clock and reset
  input  wire logic         mclk_in,
  input  wire logic         reset_in,
  // Control
  input  wire logic         load_in,
  input  wire logic [W-1:0] count_in,
  // State
  output logic      [W-1:0] remain_out,
  output logic              done_out
);
  import tkc2_pkg::*;

  // Counts down to zero and rests there
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      remain_out <= '0;
    end else if (load_in) begin
      remain_out <= count_in;
    end else if (remain_out != '0) begin
      remain_out <= remain_out - W'(1);
    end
  end

  // Last cycle of the phase
  assign done_out = (remain_out == W'(1));

  chk_timer_step: assert property (@(posedge mclk_in) disable iff (reset_in)
    (remain_out != '0 && !load_in) |=> remain_out == $past(remain_out) - W'(1))
    else $error("phase timer skipped a step");

endmodule

// [src/tkc2_comp_filter.sv]
// Comparator filter: output high when the last N samples were all ones.
// Assumes the sample is already synchronised to the clock.
`timescale 1ns/10ps
module tkc2_comp_filter #(
  parameter int DEPTH = 15
) (
  // Clock and reset
  input  wire logic       mclk_in,
  input  wire logic       reset_in,
  // Sample and length
  input  wire logic       sample_in,
  input  wire logic [3:0] len_in,
  // Filtered level
  output logic            filt_out
);
  import tkc2_pkg::*;

  logic [DEPTH-1:0] hist;
  logic [DEPTH-1:0] win;
  logic [3:0]       n;

  // A length of zero acts as one so the filter never sticks high
  assign n = (len_in == 4'h0) ? 4'h1 : len_in;

  // Window of the newest n samples
  for (genvar i = 0; i < DEPTH; i++) begin : g_win
    assign win[i] = (n > 4'(i));
  end

  // Sample history, newest in bit 0
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      hist <= '0;
    end else begin
      hist <= {hist[DEPTH-2:0], sample_in};
    end
  end

  // All samples inside the window must be ones
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      filt_out <= 1'b0;
    end else begin
      filt_out <= &(hist | ~win);
    end
  end

  chk_filter_newest: assert property (@(posedge mclk_in) disable iff (reset_in)
    filt_out |-> $past(hist[0]))
    else $error("filter high after a zero sample");

endmodule

// [src/tkc2_seq.sv]
// Sequencer of the second switched-capacitance touch-key controller.
// Assumes mclk_in is the system clock and also the oscillator tick;
// the comparator pin is asynchronous, the register port is synchronous.
// Contract
// - Only a software start begins a detection; then hardware runs it all.
// - Each detection first closes the reference discharge switch, then opens it.
// - After discharge, repeat charge and dump cycles, counting each one.
// - Filtered comparator high ends detection, stores count, raises flag.
// - Interrupt shares one vector with the first touch controller.
// - Sequencer runs on the oscillator or a reduced rate of it; here always at the full mclk_in rate.
// - Pad pull-down enabled: pad NMOS on (zero field+1)*128 clocks.
// - Discharge lasts 4+128*(zero field+1)+1 clocks, switch on throughout.
// - Filter output high only when last N oscillator samples are ones.
// - One start runs the number of detections the repeat field selects.
// - Repeated counts add into the 18-bit result; top bits in command.
// - Hardware sets the interrupt flag; software clears it by writing.
// - Writing start launches; start clears itself at completion.
// - Start clears the accumulated count; count holds after completion.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/10ps
module tkc2_seq (
  // Clock and reset
  input  wire logic                       mclk_in,
  input  wire logic                       reset_in,
  // Register port
  input  wire tkc2_pkg::tkc2_bus_t        bus_in,
  output logic [tkc2_pkg::DATA_W-1:0]     rdata_out,
  // Analog front end
  input  wire logic                       comparator_in,
  output tkc2_pkg::tkc2_front_t           front_out,
  // Interrupt vector
  input  wire logic                       touch1_irq_in,
  output logic                            irq_out
);
  import tkc2_pkg::*;

  logic [DATA_W-1:0] cfg;
  logic [DATA_W-1:0] afg;
  logic [DATA_W-1:0] mask;
  logic              int_en;
  logic              auto_shift_bit;
  logic [1:0]        repeat_field;
  logic              auto_shift_bit_run;
  logic [1:0]        rpt_run;
  logic [1:0]        status;
  logic [3:0]        reps_left;
  logic [CNT_W-1:0]  acc;
  logic [CNT_W-1:0]  cyc;
  logic [CNT_W-1:0]  cyc_inc;
  logic [CNT_W:0]    sum;
  tkc2_state_t       state;
  tkc2_state_t       next_state;
  logic              busy;
  logic              comp_s1;
  logic              comp_s2;
  logic              filt;
  logic              t_load;
  logic              t_done;
  logic [TMR_W-1:0]  t_count;
  logic [TMR_W-1:0]  t_remain;
  logic [TMR_W-1:0]  cd_len;
  logic              wr_cmd;
  logic              start_go;
  logic              det_end;
  logic              ovf_ev;
  logic [1:0]        st_set;
  logic [1:0]        st_clr;

  // Detections per start
  function automatic logic [3:0] reps_of(input logic [1:0] r);
    return 4'h1 << r;
  endfunction

  // Discharge phase length in system clocks
  function automatic logic [TMR_W-1:0] zero_len(input logic [2:0] z);
    return ZERO_PRE + ZERO_UNIT * ({8'h00, z} + LEN_ADD) + ZERO_POST;
  endfunction

  // Write and event decode
  assign wr_cmd   = bus_in.wr && (bus_in.addr == A_CMD);
  // A start while busy or disabled is ignored
  assign start_go = wr_cmd && bus_in.wdata[CMD_START] && cfg[CFG_EN] && !busy;
  assign det_end  = (state == ST_DUMP) && t_done && filt;
  assign busy     = (state != ST_IDLE);
  // Each charge-dump phase lasts the base time plus one oscillator tick
  assign cd_len   = {{(TMR_W-4){1'b0}}, cfg[CFG_CD +: 4]} + LEN_ADD;
  // Per-detection count saturates rather than wraps
  assign cyc_inc  = (&cyc) ? cyc : cyc + CNT_W'(1);
  assign sum      = {1'b0, acc} + {1'b0, cyc_inc};
  assign ovf_ev   = ((state == ST_DUMP) && t_done && (&cyc)) || (det_end && sum[CNT_W]);

  // Pin synchroniser for the comparator
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      comp_s1 <= 1'b0;
      comp_s2 <= 1'b0;
    end else begin
      comp_s1 <= comparator_in;
      comp_s2 <= comp_s1;
    end
  end

  // Comparator filter on the oscillator
  tkc2_comp_filter #(
    .DEPTH(15)
  ) u_filter (
    .mclk_in  (mclk_in),
    .reset_in (reset_in),
    .sample_in(comp_s2),
    .len_in   (afg[AFG_FIL +: 4]),
    .filt_out (filt)
  );

  // Phase timer
  tkc2_interval #(
    .W(TMR_W)
  ) u_timer (
    .mclk_in   (mclk_in),
    .reset_in  (reset_in),
    .load_in   (t_load),
    .count_in  (t_count),
    .remain_out(t_remain),
    .done_out  (t_done)
  );

  // Next state and phase loads
  always_comb begin
    next_state = state;
    t_load     = 1'b0;
    t_count    = zero_len(afg[AFG_ZERO +: 3]);
    case (state)
      ST_IDLE: begin
        if (start_go) begin
          next_state = ST_ZERO;
          t_load     = 1'b1;
        end
      end
      ST_ZERO: begin
        if (t_done) begin
          next_state = ST_CHARGE;
          t_load     = 1'b1;
          t_count    = cd_len;
        end
      end
      ST_CHARGE: begin
        if (t_done) begin
          next_state = ST_DUMP;
          t_load     = 1'b1;
          t_count    = cd_len;
        end
      end
      ST_DUMP: begin
        if (t_done) begin
          t_load = 1'b1;
          if (!filt) begin
            next_state = ST_CHARGE;
            t_count    = cd_len;
          end else if (reps_left > 4'h1) begin
            next_state = ST_ZERO;
          end else begin
            next_state = ST_FINISH;
          end
        end
      end
      ST_FINISH: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // Clearing the controller enable abandons a running sequence
    if (!cfg[CFG_EN]) begin
      next_state = ST_IDLE;
      t_load     = 1'b0;
    end
  end

  // State register
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Configuration registers
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      cfg  <= CFG_RST;
      afg  <= AFG_RST;
      mask <= MASK_RST;
    end else if (bus_in.wr) begin
      if (bus_in.addr == A_CFG) begin
        cfg <= bus_in.wdata;
      end
      if (bus_in.addr == A_AFG) begin
        afg <= bus_in.wdata;
      end
      if (bus_in.addr == A_MASK) begin
        mask <= bus_in.wdata;
      end
    end
  end

  // Command fields; the run copies freeze at start
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      int_en     <= 1'b0;
      auto_shift_bit     <= 1'b0;
      repeat_field        <= 2'h0;
      auto_shift_bit_run <= 1'b0;
      rpt_run    <= 2'h0;
    end else if (wr_cmd) begin
      int_en <= bus_in.wdata[CMD_INTEN];
      auto_shift_bit <= bus_in.wdata[CMD_SHIFT];
      repeat_field    <= bus_in.wdata[CMD_RPT +: 2];
      if (start_go) begin
        auto_shift_bit_run <= bus_in.wdata[CMD_SHIFT];
        rpt_run    <= bus_in.wdata[CMD_RPT +: 2];
      end
    end
  end

  // Repetitions still to run
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      reps_left <= 4'h0;
    end else if (start_go) begin
      reps_left <= reps_of(bus_in.wdata[CMD_RPT +: 2]);
    end else if (det_end) begin
      reps_left <= reps_left - 4'h1;
    end
  end

  // Charge-dump cycles of the current detection
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      cyc <= '0;
    end else if (state == ST_ZERO) begin
      cyc <= '0;
    end else if ((state == ST_DUMP) && t_done) begin
      cyc <= cyc_inc;
    end
  end

  // Accumulated result; it wraps past 18 bits and flags an overflow
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      acc <= '0;
    end else if (start_go) begin
      acc <= '0;
    end else if (det_end) begin
      acc <= sum[CNT_W-1:0];
    end else if ((state == ST_FINISH) && auto_shift_bit_run) begin
      acc <= acc >> rpt_run;
    end
  end

  // Sticky status; a set in the same cycle as a clear wins
  always_comb begin
    st_set           = 2'h0;
    st_set[IRQ_DONE] = (state == ST_FINISH);
    st_set[IRQ_OVF]  = ovf_ev;
    st_clr           = 2'h0;
    if (wr_cmd) begin
      st_clr[IRQ_DONE] = bus_in.wdata[CMD_FLAG];
    end
    if (bus_in.wr && (bus_in.addr == A_STAT)) begin
      st_clr = st_clr | bus_in.wdata[1:0];
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      status <= 2'h0;
    end else begin
      status <= (status & ~st_clr) | st_set;
    end
  end

  // Shared vector: this controller and the first one merge here
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= touch1_irq_in | (int_en & |(status & mask[1:0]));
    end
  end

  // Read data, valid the cycle after the strobe only
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_out <= '0;
    end else if (bus_in.rd) begin
      case (bus_in.addr)
        A_CFG:   rdata_out <= cfg;
        A_AFG:   rdata_out <= afg;
        A_CMD:   rdata_out <= {int_en, acc[CNT_W-1 -: 2], auto_shift_bit, repeat_field,
                               status[IRQ_DONE], busy};
        A_CNTL:  rdata_out <= acc[7:0];
        A_CNTH:  rdata_out <= acc[15:8];
        A_STAT:  rdata_out <= {6'h00, status};
        A_MASK:  rdata_out <= mask;
        default: rdata_out <= 8'h00;
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // Front-end drives, one clock behind the state so durations stay exact
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      front_out <= '0;
    end else begin
      front_out.ref_zero <= (state == ST_ZERO);
      front_out.pad_nmos <= (state == ST_ZERO) && afg[AFG_PAD]
                            && (t_remain > ZERO_PRE + ZERO_POST);
      front_out.charge   <= (state == ST_CHARGE);
      front_out.dump     <= (state == ST_DUMP);
      front_out.pseudo_random_enable        <= cfg[CFG_PSR];
      front_out.reference_select            <= cfg[CFG_VREF];
      front_out.comparator_threshold_select <= cfg[CFG_VTH];
    end
  end

  // Helper: cycles spent in the discharge phase
  logic [TMR_W-1:0] zcnt;
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      zcnt <= '0;
    end else if (state == ST_ZERO) begin
      zcnt <= zcnt + TMR_W'(1);
    end else begin
      zcnt <= '0;
    end
  end

  chk_start_goes_busy: assert property (@(posedge mclk_in) disable iff (reset_in)
    start_go |=> (state == ST_ZERO) && busy)
    else $error("start did not enter discharge");

  chk_zero_length: assert property (@(posedge mclk_in) disable iff (reset_in)
    ((state == ST_ZERO) && (next_state == ST_CHARGE) && $stable(afg))
    |-> zcnt + TMR_W'(1) == zero_len(afg[AFG_ZERO +: 3]))
    else $error("discharge phase length wrong");

  chk_pad_only_zero: assert property (@(posedge mclk_in) disable iff (reset_in)
    front_out.pad_nmos |-> $past(state == ST_ZERO) && $past(afg[AFG_PAD]))
    else $error("pad pull-down outside discharge");

  chk_count_step: assert property (@(posedge mclk_in) disable iff (reset_in)
    ((state == ST_DUMP) && t_done && !(&cyc) && cfg[CFG_EN])
    |=> cyc == $past(cyc) + CNT_W'(1))
    else $error("cycle count did not advance");

  chk_flag_at_end: assert property (@(posedge mclk_in) disable iff (reset_in)
    (state == ST_FINISH) |=> status[IRQ_DONE] && (state == ST_IDLE) && !busy)
    else $error("flag not raised at completion");

  chk_irq_gated: assert property (@(posedge mclk_in) disable iff (reset_in)
    (irq_out && !$past(touch1_irq_in)) |-> $past(int_en) && $past(|status))
    else $error("interrupt without flag and enable");

  chk_start_clears: assert property (@(posedge mclk_in) disable iff (reset_in)
    start_go |=> acc == '0)
    else $error("start did not clear the count");

  chk_shift_eight: assert property (@(posedge mclk_in) disable iff (reset_in)
    ((state == ST_FINISH) && auto_shift_bit_run && (rpt_run == 2'h3))
    |=> acc == ($past(acc) >> 3))
    else $error("auto-shift by three missing");

  chk_reps_loaded: assert property (@(posedge mclk_in) disable iff (reset_in)
    (start_go && (bus_in.wdata[CMD_RPT +: 2] == 2'h2)) |=> reps_left == 4'h4)
    else $error("repeat count decode wrong");

  chk_flag_set_wins: assert property (@(posedge mclk_in) disable iff (reset_in)
    st_set[IRQ_DONE] |=> status[IRQ_DONE])
    else $error("flag set lost to a clear");

endmodule

// [sim/tkc2_front_model.sv]
// Behavioural analog front end: reference cap charged one step per dump.
// Assumes the sequencer drives the front-end struct from the same clock.
`timescale 1ns/10ps
module tkc2_front_model (
  // Clock and reset
  input  wire logic                  mclk_in,
  input  wire logic                  reset_in,
  // Drives from the sequencer and the dump count that trips the comparator
  input  wire tkc2_pkg::tkc2_front_t front_in,
  input  wire logic [7:0]            target_in,
  // Comparator level
  output logic                       comparator_out
);
  import tkc2_pkg::*;
  logic [7:0] level;
  logic       dump_q;

  // Charge level: zeroed by the switch, one step per dump, saturating
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      level  <= 8'h00;
      dump_q <= 1'b0;
    end else begin
      dump_q <= front_in.dump;
      if (front_in.ref_zero) begin
        level <= 8'h00;
      end else if (front_in.dump && !dump_q && level != 8'hff) begin
        level <= level + 8'h01;
      end
    end
  end

  // Comparator stays high once reached until the discharge switch closes, as a real cap holds its charge
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      comparator_out <= 1'b0;
    end else begin
      comparator_out <= (level >= target_in) && !front_in.ref_zero;
    end
  end
endmodule

// [sim/tb.sv]
// Self-checking bench of the second touch-key sequencer.
// Assumes the front-end model in sim and the package in inc.
`timescale 1ns/10ps
module tb;
  import tkc2_pkg::*;
  logic        mclk_in    = 1'b0;
  logic        reset_in   = 1'b1;
  tkc2_bus_t   bus        = '0;
  logic [7:0]  rdata;
  logic        comparator;
  tkc2_front_t front;
  logic        touch1_irq = 1'b0;
  logic        irq;
  logic [7:0]  target     = 8'h05;
  int          err_total  = 0;
  int          total_checks = 0;
  int          zero_rises = 0;

  // 200 MHz clock
  always #2.5 mclk_in = ~mclk_in;
  // Discharge phases seen, one per detection
  always @(posedge front.ref_zero) zero_rises++;

  tkc2_seq dut (.mclk_in(mclk_in), .reset_in(reset_in), .bus_in(bus), .rdata_out(rdata),
    .comparator_in(comparator), .front_out(front), .touch1_irq_in(touch1_irq), .irq_out(irq));
  tkc2_front_model afe (.mclk_in(mclk_in), .reset_in(reset_in), .front_in(front),
    .target_in(target), .comparator_out(comparator));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge mclk_in);
    bus.wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
    @(posedge mclk_in);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge mclk_in);
    bus.rd   <= 1'b0;
    // Taken at the closing edge, before that edge returns the port to zero
    @(posedge mclk_in);
    d = rdata;
  endtask

  // Bounded poll of the busy bit
  task automatic wait_idle();
    logic [7:0] d;
    int n;
    n = 0;
    d = 8'h01;
    while (d[CMD_START] !== 1'b0) begin
      rd_reg(A_CMD, d);
      n++;
      if (n > 3000) begin
        err_total++;
        $display("unexpected timeout waiting for idle");
        conclude();
      end
    end
  endtask

  task automatic t_reset();
    logic [15:0] a [8];
    logic [7:0]  e [8];
    logic [7:0]  d;
    a = '{A_CFG, A_AFG, A_CMD, A_CNTL, A_CNTH, A_STAT, A_MASK, 16'ha157};
    e = '{CFG_RST, AFG_RST, 8'h00, 8'h00, 8'h00, 8'h00, MASK_RST, 8'h00};
    wr_reg(16'ha157, 8'hff);
    wr_reg(A_CNTL, 8'hff);
    for (int i = 0; i < 8; i++) begin
      rd_reg(a[i], d);
      check("reset value", d, e[i]);
    end
  endtask

  task automatic t_no_enable();
    logic [7:0] d;
    wr_reg(A_CFG, 8'h7f);
    wr_reg(A_CMD, 8'h01);
    repeat (4) @(posedge mclk_in);
    check("switch idle", front.ref_zero, 1'b0);
    check("cfg mirrors", {front.pseudo_random_enable, front.reference_select,
      front.comparator_threshold_select}, 3'h7);
    rd_reg(A_CMD, d);
    check("busy idle", d[CMD_START], 1'b0);
  endtask

  // Discharge length, pad pull-down length, no charge while zeroing
  task automatic t_discharge(input logic [2:0] z);
    int hz;
    int pz;
    int bad;
    int hc;
    hz = 0;
    pz = 0;
    bad = 0;
    hc = 0;
    wr_reg(A_CFG, 8'h8f);
    wr_reg(A_AFG, {1'b1, z, 4'h1});
    wr_reg(A_CMD, 8'h03);
    for (int i = 0; i < 2000; i++) begin
      @(posedge mclk_in);
      #1;
      if (front.ref_zero) hz++;
      if (front.pad_nmos) pz++;
      if (front.charge && (front.ref_zero || hz == 0)) bad++;
      if (hz > 0 && !front.ref_zero) break;
    end
    // First charge phase lasts the base time plus one tick
    for (int i = 0; i < 40 && front.charge; i++) begin
      hc++;
      @(posedge mclk_in);
      #1;
    end
    check("charge cycles", hc, 8'h10);
    check("switch cycles", hz, 4 + 128 * (z + 1) + 1);
    check("pad cycles", pz, 128 * (z + 1));
    check("charge overlap", bad, 0);
    wait_idle();
  endtask

  task automatic t_single();
    logic [7:0] d;
    target <= 8'h05;
    wr_reg(A_AFG, 8'h01);
    wr_reg(A_CMD, 8'h83);
    rd_reg(A_CMD, d);
    check("busy running", d[CMD_START], 1'b1);
    wait_idle();
    repeat (2) @(posedge mclk_in);
    rd_reg(A_CNTL, d);
    check("count", d, 8'h05);
    repeat (20) @(posedge mclk_in);
    rd_reg(A_CNTL, d);
    check("count held", d, 8'h05);
    rd_reg(A_CMD, d);
    check("command", d, 8'h82);
    check("irq set", irq, 1'b1);
    wr_reg(A_MASK, 8'h00);
    repeat (2) @(posedge mclk_in);
    check("irq masked", irq, 1'b0);
    wr_reg(A_MASK, 8'h01);
    rd_reg(A_STAT, d);
    check("status", d, 8'h01);
    wr_reg(A_CMD, 8'h82);
    repeat (2) @(posedge mclk_in);
    check("irq cleared", irq, 1'b0);
    rd_reg(A_CMD, d);
    check("flag cleared", d, 8'h80);
    touch1_irq <= 1'b1;
    repeat (2) @(posedge mclk_in);
    check("shared irq", irq, 1'b1);
    touch1_irq <= 1'b0;
    repeat (2) @(posedge mclk_in);
    check("shared irq off", irq, 1'b0);
  endtask

  // A long filter misses the first dump window and costs one more pair
  task automatic t_filter(input logic [3:0] len, input logic [7:0] extra);
    logic [7:0] d;
    target <= 8'h04;
    wr_reg(A_AFG, {4'h0, len});
    wr_reg(A_CMD, 8'h03);
    wait_idle();
    rd_reg(A_CNTL, d);
    check("filtered count", d, 8'h04 + extra);
  endtask

  task automatic t_repeat(input logic [1:0] r, input logic sh);
    logic [7:0]  d;
    logic [17:0] e;
    int          zr;
    target <= 8'h06;
    wr_reg(A_AFG, 8'h01);
    zr = zero_rises;
    wr_reg(A_CMD, {3'b000, sh, r, 2'b11});
    wait_idle();
    e = 18'd6 << r;
    if (sh) e = e >> r;
    rd_reg(A_CNTL, d);
    check("sum", d, e[7:0]);
    rd_reg(A_CMD, d);
    check("sum msb", d[6:5], e[17:16]);
    check("detections", zero_rises - zr, 1 << r);
  endtask

  initial begin
    repeat (4) @(posedge mclk_in);
    reset_in <= 1'b0;
    t_reset();
    t_no_enable();
    t_discharge(3'h0);
    t_discharge(3'h2);
    t_single();
    t_filter(4'h4, 8'h00);
    t_filter(4'hf, 8'h01);
    for (int r = 0; r < 4; r++) begin
      t_repeat(r[1:0], 1'b0);
      t_repeat(r[1:0], 1'b1);
    end
    conclude();
  end
endmodule
